// *** verilog/sfwp_params.svh ***
`ifndef SFWP_PARAMS_SVH
`define SFWP_PARAMS_SVH

// opcodes
`define SFWP_OP_SET_WEL     8'h06
`define SFWP_OP_CLR_WEL     8'h04
`define SFWP_OP_STAT_RD     8'h05
`define SFWP_OP_STAT_WR     8'h01
`define SFWP_OP_MEM_WR      8'h02
`define SFWP_OP_MEM_RD      8'h03
`define SFWP_OP_MEM_FRD     8'h0B
`define SFWP_OP_SLEEP       8'hB9
`define SFWP_OP_ID_RD       8'h9F

// status byte layout
`define SFWP_SR_PPE_BIT     7
`define SFWP_SR_ONE_BIT     6
`define SFWP_SR_Z5_BIT      5
`define SFWP_SR_Z4_BIT      4
`define SFWP_SR_BPH_BIT     3
`define SFWP_SR_BPL_BIT     2
`define SFWP_SR_WEL_BIT     1
`define SFWP_SR_Z0_BIT      0

// reset values
`define SFWP_PPE_RESET      1'h0
`define SFWP_BP_RESET       2'h0
`define SFWP_WEL_RESET      1'h0

// block protect codes and bounds
`define SFWP_BP_NONE        2'h0
`define SFWP_BP_QUARTER     2'h1
`define SFWP_BP_HALF        2'h2
`define SFWP_QUARTER_BASE   18'h30000
`define SFWP_HALF_BASE      18'h20000

// framing
`define SFWP_ADDR_W         18
`define SFWP_ADDR_LAST_BYTE 2'h2
`define SFWP_BIT_LAST       3'h7

`endif

// *** verilog/sfwp_pkg.sv ***
package sfwp_pkg;

    typedef enum logic [2:0] {
        st_opcode,
        st_addr,
        st_data,
        st_stat_wr,
        st_stat_rd,
        st_idle,
        st_ignore
    } sfwp_state_t;

    typedef logic [7:0] sfwp_byte_t;

endpackage

// *** verilog/sfwp_xfer.sv ***
`timescale 1ns/1ps

// word crossing: toggle event, data held stable until the next toggle
module sfwp_xfer #(
    parameter int W = 26
) (
    input  wire logic         src_clk,
    input  wire logic         src_rst,
    input  wire logic         src_load,
    input  wire logic [W-1:0] src_data,
    input  wire logic         dst_clk,
    input  wire logic         dst_rst,
    input  wire logic         dst_ce,
    output logic              dst_valid,
    output logic [W-1:0]      dst_data
);
    logic [W-1:0] hold_reg;
    logic         tog_reg;
    logic         meta_reg;
    logic         sync_reg;
    logic         seen_reg;

    always_ff @(posedge src_clk or posedge src_rst) begin
        if (src_rst) begin
            hold_reg <= '0;
            tog_reg  <= 1'b0;
        end else if (src_load) begin
            hold_reg <= src_data;
            tog_reg  <= ~tog_reg;
        end
    end

    always_ff @(posedge dst_clk or posedge dst_rst) begin
        if (dst_rst) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            seen_reg <= 1'b0;
        end else if (dst_ce) begin
            meta_reg <= tog_reg;
            sync_reg <= meta_reg;
            seen_reg <= sync_reg;
        end
    end

    // hold_reg is stable for a whole byte time after each toggle
    always_ff @(posedge dst_clk or posedge dst_rst) begin
        if (dst_rst) begin
            dst_valid <= 1'b0;
            dst_data  <= '0;
        end else if (dst_ce) begin
            dst_valid <= sync_reg ^ seen_reg;
            if (sync_reg ^ seen_reg) begin
                dst_data <= hold_reg;
            end
        end
    end

endmodule

// *** verilog/sfwp_top.sv ***
// Functional notes
// - exactly nine opcodes recognised, others ignored
// - 06h sets latch, 04h clears latch
// - 03h and 0Bh accepted as known opcodes, no read data returned
// - status read returns status byte on output
// - status write updates enable and protect bits
// - latch cleared after power-up, writes refused
// - only set-latch opcode sets the latch
// - latch cleared after clear, status or memory write
// - after clear-latch, status reports latch zero
// - bits: 7 pin-enable, 3/2 protect, 1 latch
// - bits 0,4,5 read 0, bit 6 reads 1
// - protect bits survive chip select cycles
// - protect code selects protected address range
// - status write refused when enabled pin low
// - pin never blocks array; latch gates array and status writes
// - 24 address bits, top six ignored
// - data stored, address increments and wraps
// - each byte committed at its eighth bit
// - protected address stops increment, drops data
// - unknown opcode: ignore frame, output stays off
// - one opcode per chip select low period
// - sample on rising, drive on falling edge
// - chip select high: input ignored, output off
`timescale 1ns/1ps
`include "sfwp_params.svh"

module sfwp_top (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        sck,
    input  wire logic        cs_n,
    input  wire logic        si,
    input  wire logic        wp_n,
    output logic             so_out,
    output logic             so_oe_n,
    output logic             mem_wr_valid,
    output logic [17:0]      mem_wr_addr,
    output logic [7:0]       mem_wr_data
);
    localparam int XW = `SFWP_ADDR_W + 8;

    sfwp_pkg::sfwp_state_t state_reg;
    sfwp_pkg::sfwp_state_t state_next;
    sfwp_pkg::sfwp_byte_t  rx_byte;
    sfwp_pkg::sfwp_byte_t  status_byte;

    logic        frame_rst;
    logic [2:0]  bit_cnt_reg;
    logic [6:0]  shift_reg;
    logic [1:0]  addr_cnt_reg;
    logic [17:0] addr_reg;
    logic        stop_reg;
    logic        wel_reg;
    logic        clr_pend_reg;
    logic        ppe_reg;
    logic [1:0]  bp_reg;
    logic        wp_meta_reg;
    logic        wp_sync_reg;
    logic [2:0]  so_cnt_reg;
    logic        byte_done;
    logic        frame_first;
    logic        opcode_done;
    logic        data_done;
    logic        commit;
    logic        stat_wr_ok;
    logic [XW-1:0] xfer_data;
    logic [XW-1:0] wr_word;

    function automatic logic is_known(input logic [7:0] op);
        case (op)
            `SFWP_OP_SET_WEL,
            `SFWP_OP_CLR_WEL,
            `SFWP_OP_STAT_RD,
            `SFWP_OP_STAT_WR,
            `SFWP_OP_MEM_WR,
            `SFWP_OP_MEM_RD,
            `SFWP_OP_MEM_FRD,
            `SFWP_OP_SLEEP,
            `SFWP_OP_ID_RD: is_known = 1'b1;
            default:        is_known = 1'b0;
        endcase
    endfunction

    function automatic logic is_protected(input logic [1:0] bp, input logic [17:0] a);
        case (bp)
            `SFWP_BP_NONE:    is_protected = 1'b0;
            `SFWP_BP_QUARTER: is_protected = (a >= `SFWP_QUARTER_BASE);
            `SFWP_BP_HALF:    is_protected = (a >= `SFWP_HALF_BASE);
            default:          is_protected = 1'b1;
        endcase
    endfunction

    // frame logic is held in reset while deselected
    assign frame_rst = rst | cs_n;

    assign rx_byte     = {shift_reg, si};
    assign byte_done   = (bit_cnt_reg == `SFWP_BIT_LAST);
    assign frame_first = (state_reg == sfwp_pkg::st_opcode) && (bit_cnt_reg == 3'h0);
    assign opcode_done = (state_reg == sfwp_pkg::st_opcode) && byte_done;
    assign data_done   = (state_reg == sfwp_pkg::st_data) && byte_done;

    // array writes gated only by latch and protect range, never by the pin
    assign commit = data_done && wel_reg && !stop_reg
                    && !is_protected(bp_reg, addr_reg);

    assign stat_wr_ok = wel_reg && !(ppe_reg && !wp_sync_reg);

    always_comb begin
        status_byte = 8'h00;
        status_byte[`SFWP_SR_PPE_BIT] = ppe_reg;
        status_byte[`SFWP_SR_ONE_BIT] = 1'b1;
        status_byte[`SFWP_SR_BPH_BIT] = bp_reg[1];
        status_byte[`SFWP_SR_BPL_BIT] = bp_reg[0];
        status_byte[`SFWP_SR_WEL_BIT] = wel_reg;
    end

    // pin synchroniser on the link clock
    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            wp_meta_reg <= 1'b1;
            wp_sync_reg <= 1'b1;
        end else begin
            wp_meta_reg <= wp_n;
            wp_sync_reg <= wp_meta_reg;
        end
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            sfwp_pkg::st_opcode: begin
                if (byte_done) begin
                    case (rx_byte)
                        `SFWP_OP_MEM_WR:  state_next = sfwp_pkg::st_addr;
                        `SFWP_OP_STAT_RD: state_next = sfwp_pkg::st_stat_rd;
                        `SFWP_OP_STAT_WR: state_next = sfwp_pkg::st_stat_wr;
                        default: begin
                            // reads, sleep and id are accepted but not served; the frame goes idle
                            if (is_known(rx_byte)) begin
                                state_next = sfwp_pkg::st_idle;
                            end else begin
                                state_next = sfwp_pkg::st_ignore;
                            end
                        end
                    endcase
                end
            end
            sfwp_pkg::st_addr: begin
                if (byte_done && (addr_cnt_reg == `SFWP_ADDR_LAST_BYTE)) begin
                    state_next = sfwp_pkg::st_data;
                end
            end
            sfwp_pkg::st_stat_wr: begin
                if (byte_done) begin
                    state_next = sfwp_pkg::st_idle;
                end
            end
            sfwp_pkg::st_data:    state_next = sfwp_pkg::st_data;
            sfwp_pkg::st_stat_rd: state_next = sfwp_pkg::st_stat_rd;
            sfwp_pkg::st_idle:    state_next = sfwp_pkg::st_idle;
            sfwp_pkg::st_ignore:  state_next = sfwp_pkg::st_ignore;
            default:              state_next = sfwp_pkg::st_ignore;
        endcase
    end

    always_ff @(posedge sck or posedge frame_rst) begin
        if (frame_rst) begin
            state_reg <= sfwp_pkg::st_opcode;
        end else begin
            state_reg <= state_next;
        end
    end

    // serial input shifter, msb first
    always_ff @(posedge sck or posedge frame_rst) begin
        if (frame_rst) begin
            bit_cnt_reg <= 3'h0;
            shift_reg   <= 7'h00;
        end else begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            shift_reg   <= rx_byte[6:0];
        end
    end

    // address assembly and sequential increment
    always_ff @(posedge sck or posedge frame_rst) begin
        if (frame_rst) begin
            addr_cnt_reg <= 2'h0;
            addr_reg     <= 18'h00000;
            stop_reg     <= 1'b0;
        end else begin
            if ((state_reg == sfwp_pkg::st_addr) && byte_done) begin
                // upper six of the 24 bits fall off the top
                addr_reg     <= {addr_reg[9:0], rx_byte};
                addr_cnt_reg <= addr_cnt_reg + 2'h1;
            end else if (commit) begin
                addr_reg <= addr_reg + 18'h00001;
            end
            if (data_done && wel_reg && is_protected(bp_reg, addr_reg)) begin
                stop_reg <= 1'b1;
            end
        end
    end

    // latch and its clear request survive deselect; the clear requested by
    // a frame is applied at the first edge of the next one, since the link
    // clock may not run after chip select rises
    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            wel_reg <= `SFWP_WEL_RESET;
        end else if (opcode_done && (rx_byte == `SFWP_OP_SET_WEL)) begin
            wel_reg <= 1'b1;
        end else if (frame_first && clr_pend_reg) begin
            wel_reg <= 1'b0;
        end
    end

    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            clr_pend_reg <= 1'b0;
        end else if (opcode_done && ((rx_byte == `SFWP_OP_CLR_WEL)
                     || (rx_byte == `SFWP_OP_STAT_WR)
                     || (rx_byte == `SFWP_OP_MEM_WR))) begin
            clr_pend_reg <= 1'b1;
        end else if (frame_first) begin
            clr_pend_reg <= 1'b0;
        end
    end

    // protect bits only reset at power-on, never by chip select
    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            ppe_reg <= `SFWP_PPE_RESET;
            bp_reg  <= `SFWP_BP_RESET;
        end else if ((state_reg == sfwp_pkg::st_stat_wr) && byte_done && stat_wr_ok) begin
            // latch bit and fixed bits of the written byte are dropped
            ppe_reg <= rx_byte[`SFWP_SR_PPE_BIT];
            bp_reg  <= {rx_byte[`SFWP_SR_BPH_BIT], rx_byte[`SFWP_SR_BPL_BIT]};
        end
    end

    // output shifter on falling edges; off while deselected
    always_ff @(negedge sck or posedge frame_rst) begin
        if (frame_rst) begin
            so_out     <= 1'b0;
            so_oe_n    <= 1'b1;
            so_cnt_reg <= 3'h0;
        end else if (state_reg == sfwp_pkg::st_stat_rd) begin
            so_out     <= status_byte[`SFWP_BIT_LAST - so_cnt_reg];
            so_oe_n    <= 1'b0;
            so_cnt_reg <= so_cnt_reg + 3'h1;
        end
    end

    assign xfer_data = {addr_reg, rx_byte};

    // committed bytes cross to the system clock for the array port
    sfwp_xfer #(
        .W (XW)
    ) u_xfer (
        .src_clk   (sck),
        .src_rst   (rst),
        .src_load  (commit),
        .src_data  (xfer_data),
        .dst_clk   (clk),
        .dst_rst   (rst),
        .dst_ce    (ce),
        .dst_valid (mem_wr_valid),
        .dst_data  (wr_word)
    );

    assign mem_wr_addr = wr_word[XW-1:8];
    assign mem_wr_data = wr_word[7:0];

endmodule

// *** verification/sfwp_top_properties.sv ***
`timescale 1ns/1ps
module sfwp_props (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        ce,
    input wire logic        sck,
    input wire logic        cs_n,
    input wire logic        si,
    input wire logic        wp_n,
    input wire logic        so_out,
    input wire logic        so_oe_n,
    input wire logic        mem_wr_valid,
    input wire logic [17:0] mem_wr_addr,
    input wire logic [7:0]  mem_wr_data
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    logic        seen_reg;
    logic        cs_q_reg;
    logic [17:0] last_reg;
    // a new frame forgets the last address so bursts are judged alone
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seen_reg <= 1'b0;
            last_reg <= 18'h0;
            cs_q_reg <= 1'b1;
        end else begin
            cs_q_reg <= cs_n;
            if (mem_wr_valid) begin
                seen_reg <= 1'b1;
                last_reg <= mem_wr_addr;
            end else if (cs_q_reg && !cs_n) begin
                seen_reg <= 1'b0;
            end
        end
    end
    AST_SO_IDLE: assert property (cs_n |-> so_oe_n)
        else $error("output driven while deselected");
    AST_OE_SEL: assert property ($fell(so_oe_n) |-> !cs_n)
        else $error("output enabled outside a frame");
    AST_SO_FALL: assert property (!cs_n && $changed(so_out) |-> !sck)
        else $error("output moved while clock high");
    AST_PULSE_ONE: assert property (mem_wr_valid |=> !mem_wr_valid)
        else $error("write pulse longer than one cycle");
    AST_ADDR_HOLD: assert property (!mem_wr_valid |-> $stable(mem_wr_addr))
        else $error("address moved without a write");
    AST_DATA_HOLD: assert property (!mem_wr_valid |-> $stable(mem_wr_data))
        else $error("data moved without a write");
    AST_IN_FRAME: assert property (mem_wr_valid |-> !$past(cs_n, 5))
        else $error("write not caused by a frame");
    AST_NEXT_ADDR: assert property (mem_wr_valid && seen_reg |->
        mem_wr_addr == last_reg + 18'h1)
        else $error("burst address not incremented");
    AST_RST_QUIET: assert property ($fell(rst) |-> so_oe_n && !mem_wr_valid)
        else $error("outputs active after reset");
endmodule

// *** verification/sfwp_spi_master.sv ***
`timescale 1ns/1ps
// mode 0 master, sck at 64 ns, idle low between frames
module sfwp_spi_master (
    output logic      sck,
    output logic      cs_n,
    output logic      si,
    input  wire logic so_out,
    input  wire logic so_oe_n
);
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end
    task open_frame;
        #35 cs_n = 1'b0;
    endtask
    // released line shows the inverse so a stale value cannot pass
    task close_frame;
        #32 cs_n = 1'b1;
        si = ~si;
        #100;
    endtask
    task xfer(input sfwp_pkg::sfwp_byte_t tx, output sfwp_pkg::sfwp_byte_t rx,
              output logic drv);
        drv = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            si = tx[i];
            #32 sck = 1'b1;
            rx[i] = so_out;
            if (so_oe_n === 1'b0) drv = 1'b1;
            #32 sck = 1'b0;
        end
    endtask
endmodule

// *** verification/spi_fram_cmd_write_protect_tb.sv ***
`timescale 1ns/1ps
module spi_fram_cmd_write_protect_tb;
    logic                 clk, rst, ce, wp_n, sck, cs_n, si, so_out, so_oe_n;
    logic                 mem_wr_valid, drv;
    logic [17:0]          mem_wr_addr;
    logic [7:0]           mem_wr_data;
    sfwp_pkg::sfwp_byte_t rx;
    logic [25:0]          got[$];
    int                   mismatches, n_compared;
    sfwp_top i_dut (.clk(clk), .rst(rst), .ce(ce), .sck(sck), .cs_n(cs_n), .si(si),
        .wp_n(wp_n), .so_out(so_out), .so_oe_n(so_oe_n), .mem_wr_valid(mem_wr_valid),
        .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data));
    sfwp_spi_master i_m (.sck(sck), .cs_n(cs_n), .si(si), .so_out(so_out),
        .so_oe_n(so_oe_n));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // sampled away from the launching edge so the pulse is seen settled
    always @(negedge clk) if (mem_wr_valid === 1'b1) got.push_back({mem_wr_addr, mem_wr_data});
    task chk(input logic [25:0] exp, input logic [25:0] act);
        n_compared++;
        if (exp !== act) begin
            mismatches++;
            $display("Error at %0t: expected %h got %h", $time, exp, act);
        end
    endtask
    task conclude;
        if (mismatches == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task cmd(input sfwp_pkg::sfwp_byte_t op);
        i_m.open_frame;
        i_m.xfer(op, rx, drv);
        i_m.close_frame;
    endtask
    task rd_sr(input sfwp_pkg::sfwp_byte_t exp, input sfwp_pkg::sfwp_byte_t mask);
        i_m.open_frame;
        i_m.xfer(8'h05, rx, drv);
        i_m.xfer(8'h00, rx, drv);
        i_m.close_frame;
        chk(exp, rx & mask);
        chk(1'b1, drv);
    endtask
    task wr_sr(input sfwp_pkg::sfwp_byte_t v);
        cmd(8'h06);
        i_m.open_frame;
        i_m.xfer(8'h01, rx, drv);
        i_m.xfer(v, rx, drv);
        i_m.close_frame;
    endtask
    task mem_wr(input logic [23:0] a, input int n, input sfwp_pkg::sfwp_byte_t d);
        got.delete();
        i_m.open_frame;
        i_m.xfer(8'h02, rx, drv);
        for (int i = 2; i >= 0; i--) i_m.xfer(a[8*i+:8], rx, drv);
        for (int i = 0; i < n; i++) i_m.xfer(d + 8'(i), rx, drv);
        i_m.close_frame;
        repeat (10) @(posedge clk);
    endtask
    task t_status;
        rd_sr(8'h40, 8'hFF);
        cmd(8'h06);
        rd_sr(8'h42, 8'hFF);
        cmd(8'h04);
        rd_sr(8'h40, 8'hFF);
    endtask
    task t_status_write_cmd;
        wr_sr(8'hFF);
        rd_sr(8'hCC, 8'hFF);
        @(negedge clk) wp_n = 1'b0;
        wr_sr(8'h00);
        rd_sr(8'hCC, 8'hFD);
        @(negedge clk) wp_n = 1'b1;
        wr_sr(8'h04);
        rd_sr(8'h44, 8'hFF);
        @(negedge clk) wp_n = 1'b0;
        wr_sr(8'h00);
        rd_sr(8'h40, 8'hFF);
    endtask
    // pin low throughout: it must not block the array
    task t_wrap;
        cmd(8'h06);
        mem_wr(24'hFFFFFF, 2, 8'h11);
        chk(2, got.size());
        chk({18'h3FFFF, 8'h11}, got[0]);
        chk({18'h00000, 8'h12}, got[1]);
        mem_wr(24'h000000, 1, 8'h33);
        chk(0, got.size());
    endtask
    task t_protect;
        int cnt[4] = '{4, 2, 0, 0};
        for (int b = 0; b < 4; b++) begin
            wr_sr({4'h4, b[1:0], 2'h0});
            cmd(8'h06);
            mem_wr(24'hFEFFFE, 4, 8'hA0);
            chk(cnt[b], got.size());
            for (int j = 0; j < got.size(); j++)
                chk({18'h2FFFE + 18'(j), 8'hA0 + 8'(j)}, got[j]);
        end
    endtask
    task t_ignore;
        sfwp_pkg::sfwp_byte_t ops[5] = '{8'h03, 8'h0B, 8'hB9, 8'h9F, 8'hA5};
        // unprotect first, so a stray write would really reach the array port
        wr_sr(8'h40);
        rd_sr(8'h40, 8'hFF);
        foreach (ops[k]) begin
            cmd(8'h06);
            got.delete();
            i_m.open_frame;
            i_m.xfer(ops[k], rx, drv);
            for (int i = 0; i < 5; i++) begin
                i_m.xfer(8'h02, rx, drv);
                chk(1'b0, drv);
            end
            i_m.close_frame;
            repeat (10) @(posedge clk);
            chk(0, got.size());
        end
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        mismatches++;
        conclude;
    end
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        wp_n = 1'b1;
        mismatches = 0;
        n_compared = 0;
        repeat (8) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        t_status;
        t_status_write_cmd;
        t_wrap;
        t_protect;
        t_ignore;
        conclude;
    end
endmodule
bind sfwp_top sfwp_props i_props (.clk(clk), .rst(rst), .ce(ce), .sck(sck), .cs_n(cs_n),
    .si(si), .wp_n(wp_n), .so_out(so_out), .so_oe_n(so_oe_n),
    .mem_wr_valid(mem_wr_valid), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data));
